/* hdl/temp_result_offset_limit.v */
// ==========================================
// Operation
// RULE1: Plain binary mode reports zero for temperatures at or below zero.
// RULE2: Extended mode adds sixty-four degrees, offset binary format.
// RULE3: Channel's signed 8-bit offset is added to every measurement.
// RULE4: One offset step equals one degree, range plus or minus 128; the code takes -128 to +127.
// RULE5: Offset registers 0x24 to 0x27, all resetting to zero.
// RULE6: Remote whole byte at 0x0D, quarter bits in 0x08 bits 1:0.
// RULE7: Local whole byte at 0x0E, quarter bits in 0x09 bits 1:0.
// RULE8: Exceeding high or low limit sets the channel's status bit.
// RULE9: Limit violations can drive active-low alert, subject to mask.
// RULE10: Remote/local lows 0x1A/0x1C reset 0x00, highs 0x1B/0x1D reset 0x7F.
// RULE11: Analog limits 0x14 to 0x17, lows 0x00, highs 0xFF.
// RULE12: Host writes limits in the active measurement format.
// RULE13: Thermistor readings scaled so one step equals a quarter degree.
// RULE14: Config 0x01 bit 0 picks 10k (one) or 100k (zero) scaling.
// RULE15: Config 0x00 bit 7 selects plain or offset-binary range.
// RULE16: High check is strictly greater; low check is less or equal.
// RULE17: Reading a fraction register first freezes results until all read.
// RULE18: Status bits sticky until read after the condition clears.
// RULE19: Offset sums saturate at the format limits instead of wrapping.
`include "temp_result_regs.vh"
module temp_result_offset_limit #(
    parameter RAW_W = 12
) (
    input  wire             CLK,
    input  wire             RST_B,
    input  wire [7:0]       REG_ADDR,
    input  wire [7:0]       REG_WDATA,
    input  wire             REG_WR,
    input  wire             REG_RD,
    output reg  [7:0]       REG_RDATA,
    input  wire [RAW_W-1:0] REMOTE_RAW,
    input  wire             REMOTE_VALID,
    input  wire [RAW_W-1:0] LOCAL_RAW,
    input  wire             LOCAL_VALID,
    input  wire [RAW_W-1:0] INPUT1_RAW,
    input  wire             INPUT1_VALID,
    input  wire [RAW_W-1:0] INPUT2_RAW,
    input  wire             INPUT2_VALID,
    output reg              ALERT_B
);
    // ==========================================
    // Configuration, limit, result, status and freeze registers
    reg [7:0] config1_r;
    reg [7:0] config2_r;
    reg [7:0] config3_r;
    reg [7:0] mask_r;
    reg [7:0] low_r    [0:3];
    reg [7:0] high_r   [0:3];
    reg [7:0] adjust_r [0:3];
    reg [9:0] result_r [0:3];
    reg [3:0] cond_r;
    reg [3:0] sticky_r;
    reg       frozen_r;
    reg [3:0] read_seen_r;
    // Channel index: 0 input1, 1 input2, 2 remote, 3 local
    wire [RAW_W-1:0] raw   [0:3];
    wire [3:0]       valid;
    wire [9:0]       fmt   [0:3];
    wire [3:0]       ool;
    wire             ext   = config1_r[`CFG1_EXT_RANGE_BIT];          // see RULE15
    wire             ten_k = config2_r[`CFG2_TEN_K_BIT];              // see RULE14
    assign valid = {LOCAL_VALID, REMOTE_VALID, INPUT2_VALID, INPUT1_VALID};
    assign raw[2] = REMOTE_RAW;
    assign raw[3] = LOCAL_RAW;
    // ==========================================
    // Thermistor normalisation to quarter degrees
    // Raw codes stay 1/4 degree per step; the two scalings differ only in
    // fixed offset, kept as constants so calibration can change them.
    function [RAW_W-1:0] norm;
        input [RAW_W-1:0] code;
        input             therm;
        input             tenk;
        begin
            if (!therm)
                norm = code;
            else if (tenk)
                norm = code + `THERM_OFFSET_10K;                     // see RULE13 see RULE14
            else
                norm = code + `THERM_OFFSET_100K;                    // see RULE13
        end
    endfunction
    assign raw[0] = norm(INPUT1_RAW, config3_r[`CFG3_THERM1_BIT], ten_k);
    assign raw[1] = norm(INPUT2_RAW, config3_r[`CFG3_THERM2_BIT], ten_k);
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : ch
            channel_result #(
                .W            (RAW_W)
            ) u_ch (
                .raw          (raw[g]),
                .adjust       (adjust_r[g]),
                .ext_range    (ext),
                .low_bound    (low_r[g]),
                .high_bound   (high_r[g]),
                .result       (fmt[g]),
                .out_of_limit (ool[g])
            );
        end
    endgenerate
    // ==========================================
    // Read decode
    wire rd_frac   = REG_RD && (REG_ADDR == `OFS_REMOTE_FRAC || REG_ADDR == `OFS_LOCAL_FRAC);
    wire rd_status = REG_RD && (REG_ADDR == `OFS_STATUS);
    reg  [3:0] rd_hit;
    reg  [7:0] rdata_nxt;
    reg  [7:0] status_val;
    always @* begin
        rd_hit = 4'h0;
        if (REG_RD) begin
            case (REG_ADDR)
                `OFS_INPUT1_RESULT: rd_hit = 4'h1;
                `OFS_INPUT2_RESULT: rd_hit = 4'h2;
                `OFS_REMOTE_RESULT: rd_hit = 4'h4;
                `OFS_LOCAL_RESULT:  rd_hit = 4'h8;
                `OFS_REMOTE_FRAC:   rd_hit = 4'h4;
                `OFS_LOCAL_FRAC:    rd_hit = 4'h8;
                default:            rd_hit = 4'h0;
            endcase
        end
    end
    always @* begin
        status_val = 8'h00;
        status_val[`STATUS_INPUT1_BIT] = sticky_r[0];
        status_val[`STATUS_INPUT2_BIT] = sticky_r[1];
        status_val[`STATUS_REMOTE_BIT] = sticky_r[2];
        status_val[`STATUS_LOCAL_BIT]  = sticky_r[3];
        status_val[`STATUS_ANY_BIT]    = |sticky_r;
        case (REG_ADDR)
            `OFS_CONFIG1:       rdata_nxt = config1_r;
            `OFS_CONFIG2:       rdata_nxt = config2_r;
            `OFS_CONFIG3:       rdata_nxt = config3_r;
            `OFS_REMOTE_FRAC:   rdata_nxt = {6'h00, result_r[2][1:0]};   // see RULE6
            `OFS_LOCAL_FRAC:    rdata_nxt = {6'h00, result_r[3][1:0]};   // see RULE7
            `OFS_INPUT1_RESULT: rdata_nxt = result_r[0][9:2];
            `OFS_INPUT2_RESULT: rdata_nxt = result_r[1][9:2];
            `OFS_REMOTE_RESULT: rdata_nxt = result_r[2][9:2];            // see RULE6
            `OFS_LOCAL_RESULT:  rdata_nxt = result_r[3][9:2];            // see RULE7
            `OFS_STATUS:        rdata_nxt = status_val;
            `OFS_MASK:          rdata_nxt = mask_r;
            `OFS_INPUT1_LOW:    rdata_nxt = low_r[0];
            `OFS_INPUT1_HIGH:   rdata_nxt = high_r[0];
            `OFS_INPUT2_LOW:    rdata_nxt = low_r[1];
            `OFS_INPUT2_HIGH:   rdata_nxt = high_r[1];
            `OFS_REMOTE_LOW:    rdata_nxt = low_r[2];
            `OFS_REMOTE_HIGH:   rdata_nxt = high_r[2];
            `OFS_LOCAL_LOW:     rdata_nxt = low_r[3];
            `OFS_LOCAL_HIGH:    rdata_nxt = high_r[3];
            `OFS_INPUT1_ADJ:    rdata_nxt = adjust_r[0];
            `OFS_INPUT2_ADJ:    rdata_nxt = adjust_r[1];
            `OFS_REMOTE_ADJ:    rdata_nxt = adjust_r[2];
            `OFS_LOCAL_ADJ:     rdata_nxt = adjust_r[3];
            default:            rdata_nxt = 8'h00;
        endcase
    end
    // ==========================================
    // Freeze control: released once all four result channels were read
    wire [3:0] seen_nxt = read_seen_r | rd_hit;
    integer i;
    always @(posedge CLK) begin
        if (!RST_B) begin
            frozen_r    <= 1'b0;
            read_seen_r <= 4'h0;
        end else if (!frozen_r) begin
            frozen_r    <= rd_frac;                                   // see RULE17
            read_seen_r <= rd_frac ? rd_hit : 4'h0;
        end else if (&seen_nxt) begin
            frozen_r    <= 1'b0;                                      // see RULE17
            read_seen_r <= 4'h0;
        end else begin
            read_seen_r <= seen_nxt;
        end
    end
    // ==========================================
    // Register writes, result capture, status
    always @(posedge CLK) begin
        if (!RST_B) begin
            config1_r <= `RST_ZERO;
            config2_r <= `RST_ZERO;                                   // see RULE14
            config3_r <= `RST_ZERO;
            mask_r    <= `RST_MASK;
            for (i = 0; i < 4; i = i + 1) begin
                adjust_r[i] <= `RST_ZERO;                             // see RULE5
                result_r[i] <= 10'h000;                               // see RULE6 see RULE7
                low_r[i]    <= `RST_ZERO;                             // see RULE10 see RULE11
            end
            high_r[0] <= `RST_ANALOG_HIGH;                            // see RULE11
            high_r[1] <= `RST_ANALOG_HIGH;
            high_r[2] <= `RST_TEMP_HIGH;                              // see RULE10
            high_r[3] <= `RST_TEMP_HIGH;
            cond_r    <= 4'h0;
            sticky_r  <= 4'h0;
            REG_RDATA <= 8'h00;
            ALERT_B   <= 1'b1;
        end else begin
            REG_RDATA <= REG_RD ? rdata_nxt : 8'h00;
            if (REG_WR) begin
                case (REG_ADDR)
                    `OFS_CONFIG1:     config1_r   <= REG_WDATA;
                    `OFS_CONFIG2:     config2_r   <= REG_WDATA;
                    `OFS_CONFIG3:     config3_r   <= REG_WDATA;
                    `OFS_MASK:        mask_r      <= REG_WDATA;
                    `OFS_INPUT1_LOW:  low_r[0]    <= REG_WDATA;
                    `OFS_INPUT1_HIGH: high_r[0]   <= REG_WDATA;
                    `OFS_INPUT2_LOW:  low_r[1]    <= REG_WDATA;
                    `OFS_INPUT2_HIGH: high_r[1]   <= REG_WDATA;
                    `OFS_REMOTE_LOW:  low_r[2]    <= REG_WDATA;
                    `OFS_REMOTE_HIGH: high_r[2]   <= REG_WDATA;
                    `OFS_LOCAL_LOW:   low_r[3]    <= REG_WDATA;
                    `OFS_LOCAL_HIGH:  high_r[3]   <= REG_WDATA;
                    `OFS_INPUT1_ADJ:  adjust_r[0] <= REG_WDATA;           // see RULE5
                    `OFS_INPUT2_ADJ:  adjust_r[1] <= REG_WDATA;
                    `OFS_REMOTE_ADJ:  adjust_r[2] <= REG_WDATA;
                    `OFS_LOCAL_ADJ:   adjust_r[3] <= REG_WDATA;
                    default: ;
                endcase
            end
            for (i = 0; i < 4; i = i + 1) begin
                // A frozen result drops new samples; limit checks still run
                if (valid[i] && !frozen_r)
                    result_r[i] <= fmt[i];                            // see RULE17
                if (valid[i])
                    cond_r[i] <= ool[i];
                // Set wins over the read-clear in the same cycle
                if (valid[i] && ool[i])
                    sticky_r[i] <= 1'b1;                              // see RULE8
                else if (rd_status && !cond_r[i])
                    sticky_r[i] <= 1'b0;                              // see RULE18
            end
            ALERT_B <= ~|(sticky_r & ~{mask_r[`STATUS_LOCAL_BIT], mask_r[`STATUS_REMOTE_BIT],
                          mask_r[`STATUS_INPUT2_BIT], mask_r[`STATUS_INPUT1_BIT]}); // see RULE9
        end
    end
endmodule

/* hdl/temp_result_regs.vh */
`ifndef TEMP_RESULT_REGS_VH
`define TEMP_RESULT_REGS_VH
// ==========================================
// Register offsets
`define OFS_CONFIG1          8'h00
`define OFS_CONFIG2          8'h01
`define OFS_CONFIG3          8'h02
`define OFS_REMOTE_FRAC      8'h08
`define OFS_LOCAL_FRAC       8'h09
`define OFS_INPUT1_RESULT    8'h0A
`define OFS_INPUT2_RESULT    8'h0B
`define OFS_REMOTE_RESULT    8'h0D
`define OFS_LOCAL_RESULT     8'h0E
`define OFS_STATUS           8'h10
`define OFS_MASK             8'h12
`define OFS_INPUT1_LOW       8'h14
`define OFS_INPUT1_HIGH      8'h15
`define OFS_INPUT2_LOW       8'h16
`define OFS_INPUT2_HIGH      8'h17
`define OFS_REMOTE_LOW       8'h1A
`define OFS_REMOTE_HIGH      8'h1B
`define OFS_LOCAL_LOW        8'h1C
`define OFS_LOCAL_HIGH       8'h1D
`define OFS_INPUT1_ADJ       8'h24
`define OFS_INPUT2_ADJ       8'h25
`define OFS_REMOTE_ADJ       8'h26
`define OFS_LOCAL_ADJ        8'h27
// ==========================================
// Field positions
`define CFG1_EXT_RANGE_BIT   7
`define CFG2_SECOND_DIODE    7
`define CFG2_TEN_K_BIT       0
`define CFG3_THERM1_BIT      7
`define CFG3_THERM2_BIT      6
`define STATUS_ANY_BIT       7
`define STATUS_INPUT1_BIT    6
`define STATUS_INPUT2_BIT    5
`define STATUS_REMOTE_BIT    2
`define STATUS_LOCAL_BIT     1
// ==========================================
// Reset values
`define RST_ZERO             8'h00
`define RST_TEMP_HIGH        8'h7F
`define RST_ANALOG_HIGH      8'hFF
`define RST_MASK             8'h00
// ==========================================
// Format and normalisation constants
`define EXT_OFFSET           12'h100
`define FMT_MAX_PLAIN        12'h1FF
`define FMT_MAX_EXT          12'h3FF
`define THERM_OFFSET_100K    12'h000
`define THERM_OFFSET_10K     12'h000
`endif

/* hdl/channel_result.v */
`include "temp_result_regs.vh"
// Offset, formatting, saturation and limit checks for one channel
module channel_result #(
    parameter W = 12
) (
    input  wire [W-1:0] raw,
    input  wire [7:0]   adjust,
    input  wire         ext_range,
    input  wire [7:0]   low_bound,
    input  wire [7:0]   high_bound,
    output reg  [9:0]   result,
    output wire         out_of_limit
);
    // raw is signed temperature in quarter degrees
    reg signed [W+1:0] sum;
    reg signed [W+1:0] hi;
    always @* begin
        sum = $signed({raw[W-1], raw[W-1], raw})
            + $signed({{(W-8){adjust[7]}}, adjust, 2'b00});            // see RULE3 see RULE4
        if (ext_range) begin
            sum = sum + $signed({2'b00, `EXT_OFFSET});                 // see RULE2
            hi  = $signed({2'b00, `FMT_MAX_EXT});
        end else begin
            hi  = $signed({2'b00, `FMT_MAX_PLAIN});
        end
        if (sum < 0)
            result = 10'h000;                                         // see RULE1 see RULE19
        else if (sum > hi)
            result = hi[9:0];                                         // see RULE19
        else
            result = sum[9:0];
    end
    // Limits compare against the whole-degree byte only
    assign out_of_limit = (result[9:2] > high_bound) || (result[9:2] <= low_bound); // see RULE16
endmodule

/* tb/result_checker_sva.sv */
// ==========================================
// Port checker for the result, limit and alert logic
module result_checker #(
    parameter RAW_W = 12
) (
    input wire logic             CLK,
    input wire logic             RST_B,
    input wire logic [7:0]       REG_ADDR,
    input wire logic [7:0]       REG_WDATA,
    input wire logic             REG_WR,
    input wire logic             REG_RD,
    input wire logic [7:0]       REG_RDATA,
    input wire logic [RAW_W-1:0] REMOTE_RAW,
    input wire logic             REMOTE_VALID,
    input wire logic [RAW_W-1:0] LOCAL_RAW,
    input wire logic             LOCAL_VALID,
    input wire logic [RAW_W-1:0] INPUT1_RAW,
    input wire logic             INPUT1_VALID,
    input wire logic [RAW_W-1:0] INPUT2_RAW,
    input wire logic             INPUT2_VALID,
    input wire logic             ALERT_B
);
    // Shadow of host writes; only read-write places are looked at
    logic [7:0] sh_r [0:63];
    logic       plain;
    logic       clr;
    assign plain = !sh_r[0][7] && sh_r[38] == 8'h00 && sh_r[18] == 8'h00;
    assign clr   = (REG_RD && REG_ADDR == 8'h10) || (REG_WR && REG_ADDR == 8'h12);
    always @(posedge CLK) begin
        if (!RST_B) begin
            for (int i = 0; i < 64; i++)
                sh_r[i] <= (i == 21 || i == 23) ? 8'hFF : (i == 27 || i == 29) ? 8'h7F : 8'h00;
        end else if (REG_WR && REG_ADDR < 8'h40) begin
            sh_r[REG_ADDR[5:0]] <= REG_WDATA;
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    sequence s_rd(logic [7:0] a);
        REG_RD && REG_ADDR == a;
    endsequence
    // Plain range, no offset: a raw code at or above the next whole degree is over the bound
    sequence s_hot;
        REMOTE_VALID && plain && sh_r[27] < 8'h7F
            && $signed(REMOTE_RAW) >= $signed({2'b00, sh_r[27] + 8'h01, 2'b00});
    endsequence
    sequence s_cold;
        REMOTE_VALID && plain && REMOTE_RAW[RAW_W-1:9] == '0 && REMOTE_RAW[9:2] <= sh_r[26];
    endsequence
    property p_rem_high;
        s_rd(8'h1B) |=> REG_RDATA == $past(sh_r[27]);
    endproperty
    property p_in1_high;
        s_rd(8'h15) |=> REG_RDATA == $past(sh_r[21]);
    endproperty
    property p_in1_adj;
        s_rd(8'h24) |=> REG_RDATA == $past(sh_r[36]);
    endproperty
    property p_frac;
        REG_RD && (REG_ADDR == 8'h08 || REG_ADDR == 8'h09) |=> REG_RDATA[7:2] == 6'h00;
    endproperty
    property p_high;
        s_hot |-> ##[1:3] !ALERT_B;
    endproperty
    property p_low;
        s_cold |-> ##[1:3] !ALERT_B;
    endproperty
    property p_mask;
        $past(sh_r[18]) == 8'hFF && sh_r[18] == 8'hFF |-> ALERT_B;
    endproperty
    property p_rose;
        $rose(ALERT_B) |-> $past(clr) || $past(clr, 2) || $past(clr, 3);
    endproperty
    a_rem_high: assert property (p_rem_high) else $error("remote high bound readback wrong");
    a_in1_high: assert property (p_in1_high) else $error("input1 high bound readback wrong");
    a_in1_adj: assert property (p_in1_adj) else $error("input1 adjust readback wrong");
    a_frac: assert property (p_frac) else $error("fraction register upper bits set");
    a_high: assert property (p_high) else $error("over-bound reading raised no alert");
    a_low: assert property (p_low) else $error("at-low-bound reading raised no alert");
    a_mask: assert property (p_mask) else $error("alert low while fully masked");
    a_rose: assert property (p_rose) else $error("alert cleared without status read");
endmodule
bind temp_result_offset_limit result_checker #(.RAW_W(RAW_W)) chk (
    .CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REMOTE_RAW(REMOTE_RAW), .REMOTE_VALID(REMOTE_VALID),
    .LOCAL_RAW(LOCAL_RAW), .LOCAL_VALID(LOCAL_VALID), .INPUT1_RAW(INPUT1_RAW),
    .INPUT1_VALID(INPUT1_VALID), .INPUT2_RAW(INPUT2_RAW), .INPUT2_VALID(INPUT2_VALID),
    .ALERT_B(ALERT_B));

/* tb/reg_host.sv */
// ==========================================
// Host side of the register strobe bus
module reg_host (
    input  wire logic       CLK,
    output logic      [7:0] REG_ADDR,
    output logic      [7:0] REG_WDATA,
    output logic            REG_WR,
    output logic            REG_RD,
    input  wire logic [7:0] REG_RDATA
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
    end
    // Idle address is inverted after each access, and write data after a write, so nothing leans on a stale value
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge CLK);
        REG_ADDR = a;
        REG_WDATA = v;
        REG_WR = 1'b1;
        @(negedge CLK);
        REG_WR = 1'b0;
        REG_ADDR = ~a;
        REG_WDATA = ~v;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge CLK);
        REG_ADDR = a;
        REG_RD = 1'b1;
        @(negedge CLK);
        REG_RD = 1'b0;
        REG_ADDR = ~a;
        v = REG_RDATA;
    endtask
endmodule

/* tb/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        CLK = 1'b0;
    logic        RST_B = 1'b0;
    logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, d, lo, hi, b;
    logic        REG_WR, REG_RD, ALERT_B, ext, flag;
    logic [11:0] rw [4] = '{default: 12'h000};
    logic [3:0]  vld = 4'h0;
    logic [7:0]  av [4];
    int          ex [4];
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cyc = 0;
    logic [7:0]  ra [18] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h14, 8'h15, 8'h16,
                             8'h17, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h24, 8'h25, 8'h26, 8'h27};
    logic [7:0]  rv [18] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00,
                             8'hFF, 8'h00, 8'h7F, 8'h00, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [24:0] lt [7] = '{25'h0143232, 25'h0143233, 25'h0143214, 25'h0143215,
                            25'h1547273, 25'h1547240, 25'h1547272};
    reg_host host (.CLK(CLK), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
                   .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
    temp_result_offset_limit #(.RAW_W(12)) dut (.CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .INPUT1_RAW(rw[0]), .INPUT1_VALID(vld[0]), .INPUT2_RAW(rw[1]), .INPUT2_VALID(vld[1]),
        .REMOTE_RAW(rw[2]), .REMOTE_VALID(vld[2]), .LOCAL_RAW(rw[3]), .LOCAL_VALID(vld[3]),
        .ALERT_B(ALERT_B));
    always #12.5 CLK = ~CLK;
    // ==========================================
    // Reference model and helpers
    function automatic int model(logic [11:0] r, logic [7:0] a, logic e);
        int v;
        v = int'($signed(r)) + int'($signed(a)) * 4 + (e ? 256 : 0);
        v = v < 0 ? 0 : v;
        return v > (e ? 1023 : 511) ? (e ? 1023 : 511) : v;
    endfunction
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic send(input logic [3:0] ch);
        @(negedge CLK);
        vld = ch;
        @(negedge CLK);
        vld = 4'h0;
    endtask
    // Remote reading at a whole-degree code; alert is checked two cycles after the sample
    task automatic hot(input logic [7:0] v, input logic ea);
        rw[2] = {2'b00, v - (ext ? 8'h40 : 8'h00), 2'b00};
        send(4'h4);
        repeat (2) @(negedge CLK);
        chk("ALERT_B", {7'h00, ALERT_B}, {7'h00, ea});
        host.rd(8'h10, d);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(57));
        repeat (8) @(negedge CLK);
        RST_B = 1'b1;
        for (int i = 0; i < 18; i++) begin
            host.rd(ra[i], d);
            chk("reset value", d, rv[i]);
            if (i > 5) begin
                host.wr(ra[i], rv[i] ^ 8'h5A);
                host.rd(ra[i], d);
                chk("readback", d, rv[i] ^ 8'h5A);
                host.wr(ra[i], rv[i]);
            end
        end
        host.rd(8'h3F, d);
        chk("unmapped", d, 8'h00);
        host.wr(8'h02, 8'hC0);
        for (int n = 0; n < 30; n++) begin
            ext = 1'($urandom_range(0, 1));
            host.wr(8'h00, {ext, 7'h01});
            host.wr(8'h01, {7'h00, 1'($urandom_range(0, 1))});
            for (int i = 0; i < 4; i++) begin
                av[i] = 8'($urandom_range(0, 255));
                rw[i] = 12'($urandom_range(0, 4095));
                host.wr(8'h24 + 8'(i), av[i]);
                ex[i] = model(rw[i], av[i], ext);
            end
            send(4'hF);
            host.wr(8'h0D, 8'h5A);
            host.rd(8'h08, d);
            chk("remote_fraction_bits", d, {6'h00, 2'(ex[2])});
            rw[2] = ~rw[2];
            send(4'h4);
            host.rd(8'h09, d);
            chk("local_fraction_bits", d, {6'h00, 2'(ex[3])});
            for (int i = 0; i < 4; i++) begin
                host.rd(ra[i + 2], d);
                chk("result", d, 8'(ex[i] >> 2));
            end
        end
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h24 + 8'(i), 8'h00);
            rw[i] = 12'h064;
        end
        host.wr(8'h00, 8'h01);
        send(4'hF);
        host.rd(8'h10, d);
        host.rd(8'h10, d);
        chk("status", d, 8'h00);
        for (int n = 0; n < 7; n++) begin
            {ext, lo, hi, b} = lt[n];
            host.wr(8'h00, {ext, 7'h01});
            host.wr(8'h1A, lo);
            host.wr(8'h1B, hi);
            flag = b > hi || b <= lo;
            hot(b, ~flag);
            chk("status", d, {flag, 4'h0, flag, 2'h0});
            if (flag) begin
                hot(lo + 8'h01, 1'b0);
                chk("status", d, 8'h84);
                host.rd(8'h10, d);
                chk("status", d, 8'h00);
                repeat (2) @(negedge CLK);
                chk("ALERT_B", {7'h00, ALERT_B}, 8'h01);
            end
        end
        host.wr(8'h12, 8'hFF);
        hot(8'h73, 1'b1);
        chk("status", d, 8'h84);
        host.wr(8'h12, 8'h00);
        repeat (2) @(negedge CLK);
        chk("ALERT_B", {7'h00, ALERT_B}, 8'h00);
        // Local over its high bound and input1 below its low bound set their own bits
        host.wr(8'h00, 8'h01);
        host.wr(8'h1D, 8'h10);
        host.wr(8'h14, 8'h30);
        rw[3] = 12'h064;
        rw[0] = 12'h064;
        send(4'h9);
        host.rd(8'h10, d);
        chk("status", d, 8'hC6);
        wrap_up();
    end
endmodule
